//--- bench/dct_top_sva.sv
// port-level assertions of the dual timer control block
`timescale 1ns/1ns
module dct_top_sva (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire dct_pkg::dct_capture_t word_capture,
  input wire logic word_timer_output,
  input wire logic port_out_byte,
  input wire logic port_out_combined,
  input wire logic byte_timer_out_pin,
  input wire logic combined_out_pin,
  input wire logic word_timer_forced_output,
  input wire logic [15:0] word_timer_reload,
  input wire dct_pkg::dct_ctrl1_t shared_ctrl,
  input wire dct_pkg::dct_edge_t edge_detect,
  input wire logic timeout_irq,
  input wire logic capture_irq
);
  logic [15:0] cap_q;
  logic route_q;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // shadow of the last captured word
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) cap_q <= 16'h0000;
    else if (word_capture.strobe) cap_q <= word_capture.value;
  end
  // shadow of the byte pin routing bit
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) route_q <= 1'b0;
    else if (reg_wr_en && reg_addr == 4'h0) route_q <= reg_wdata[0];
  end
  capture_read_a: assert property (
    reg_rd_en && reg_addr[3:1] == 3'h4 |=> reg_rdata ==
    ($past(reg_addr[0]) ? $past(cap_q[15:8]) : $past(cap_q[7:0])))
    else $error("capture byte read wrong");
  reload_write_a: assert property (
    reg_wr_en && reg_addr[3:1] == 3'h3 |=> $past(reg_wdata) ==
    ($past(reg_addr[0]) ? word_timer_reload[15:8] : word_timer_reload[7:0]))
    else $error("reload byte not stored");
  shared_write_a: assert property (
    reg_wr_en && reg_addr == 4'h1 && !shared_ctrl.demod && !reg_wdata[7]
    |=> shared_ctrl == $past(reg_wdata)) else $error("shared control not stored");
  byte_route_a: assert property (
    !route_q |=> byte_timer_out_pin == $past(port_out_byte))
    else $error("byte pin not port output");
  combined_route_a: assert property (
    shared_ctrl.demod || !shared_ctrl.pin_sel |=> combined_out_pin == $past(port_out_combined))
    else $error("combined pin not port output");
  word_force_a: assert property (
    !shared_ctrl.demod && shared_ctrl.submode_filter[1]
    |=> word_timer_forced_output == $past(shared_ctrl.submode_filter[0]))
    else $error("word output not forced");
  word_pass_a: assert property (
    !shared_ctrl.demod && !shared_ctrl.submode_filter[1]
    |=> word_timer_forced_output == $past(word_timer_output))
    else $error("word output not passed through");
  capture_edge_a: assert property (
    capture_irq |-> edge_detect.rise || edge_detect.fall)
    else $error("capture irq without edge");
  timeout_pulse_a: assert property (
    timeout_irq |=> !timeout_irq) else $error("timeout irq longer than one cycle");
  cover property (timeout_irq);
  cover property (capture_irq);
  cover property (edge_detect.fall);
endmodule

//--- bench/dct_top_tb.sv
// self-checking bench of the dual timer control block
`timescale 1ns/1ns
module dct_top_tb;
  logic mclk = 1'b0;
  logic rst_n, wr, rd, port_b, port_c, pin_a, pin_b, cap_go, wto, p;
  logic bpin, cpin, bout, wfo, to_irq, cap_irq;
  logic [3:0] addr;
  logic [7:0] wdata, rdata;
  logic [15:0] cap_val, reload;
  dct_pkg::dct_capture_t wcap;
  dct_pkg::dct_ctrl1_t sctl;
  dct_pkg::dct_edge_t edg;
  int fails, n_checks, k, n;
  dct_word_model dct_word_model_i (.mclk(mclk), .rst_n(rst_n), .cap_go(cap_go),
    .cap_val(cap_val), .word_capture(wcap), .word_timer_output(wto));
  dct_top dct_top_i (.mclk(mclk), .rst_n(rst_n), .reg_addr(addr), .reg_wr_en(wr),
    .reg_rd_en(rd), .reg_wdata(wdata), .reg_rdata(rdata), .word_capture(wcap),
    .word_timer_output(wto), .port_out_byte(port_b), .port_out_combined(port_c),
    .demod_input_pin_a(pin_a), .demod_input_pin_b(pin_b), .byte_timer_out_pin(bpin),
    .combined_out_pin(cpin), .byte_timer_output(bout), .word_timer_forced_output(wfo),
    .word_timer_reload(reload), .shared_ctrl(sctl), .edge_detect(edg),
    .timeout_irq(to_irq), .capture_irq(cap_irq));
  always #25 mclk = ~mclk;
  // port latches keep moving so the routing checks can tell them apart
  always @(negedge mclk) begin
    port_b <= rst_n ? ~port_b : 1'b0;
    port_c <= rst_n ? port_b : 1'b1;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t mismatch got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(negedge mclk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge mclk);
    wr = 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
    @(negedge mclk);
    addr = a;
    rd = 1'b1;
    @(negedge mclk);
    rd = 1'b0;
    chk(16'(rdata), 16'(e));
  endtask
  // counts cycles until the chosen irq pulses, lim if never
  task automatic wait_irq(input logic cap, input int lim, output int c);
    c = 0;
    while (((cap ? cap_irq : to_irq) !== 1'b1) && c < lim) begin
      @(negedge mclk);
      c++;
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #(20000 * 50);
    fails++;
    report_and_stop();
  end
  initial begin
    rst_n = 1'b0;
    {wr, rd, pin_a, pin_b, cap_go, addr, wdata, cap_val} = '0;
    repeat (4) @(negedge mclk);
    rst_n = 1'b1;
    for (int i = 0; i < 16; i++) rd_reg(4'(i), 8'h00);
    wr_reg(4'h4, 8'h04);
    wr_reg(4'h5, 8'h03);
    wr_reg(4'h6, 8'ha5);
    wr_reg(4'h7, 8'h5a);
    rd_reg(4'h4, 8'h04);
    rd_reg(4'h5, 8'h03);
    rd_reg(4'h6, 8'ha5);
    rd_reg(4'h7, 8'h5a);
    chk(reload, 16'h5aa5);
    @(negedge mclk);
    cap_val = 16'hbeef;
    cap_go = 1'b1;
    @(negedge mclk);
    cap_go = 1'b0;
    wr_reg(4'h8, 8'h00);
    wr_reg(4'h9, 8'h00);
    rd_reg(4'h8, 8'hef);
    rd_reg(4'h9, 8'hbe);
    wr_reg(4'h3, 8'hff);
    rd_reg(4'h3, 8'h00);
    for (int s = 0; s < 4; s++) begin
      wr_reg(4'h0, 8'he2 | 8'(s << 3));
      wait_irq(1'b0, 60, k);
      chk(16'(k >= 3 * (1 << s) + 1 && k <= 4 * (1 << s) + 3), 16'h1);
      rd_reg(4'h0, 8'h62 | 8'(s << 3));
    end
    wr_reg(4'h0, 8'h5a);
    rd_reg(4'h0, 8'h7a);
    wr_reg(4'h0, 8'h7a);
    rd_reg(4'h0, 8'h5a);
    wr_reg(4'h0, 8'h80);
    {k, n, p} = '0;
    repeat (40) begin
      @(negedge mclk);
      k += int'(bout !== p);
      p = bout;
      n += int'(to_irq === 1'b1);
    end
    chk(16'(k > 4), 16'h1);
    chk(16'(n), 16'h0);
    rd_reg(4'h0, 8'ha0);
    wr_reg(4'h0, 8'h01);
    repeat (3) @(negedge mclk);
    chk(16'({bpin, bout}), 16'h3);
    for (int i = 0; i < 8; i++) begin
      wr_reg(4'h1, 8'h48 | 8'((i >> 1) << 4) | 8'((i & 1) << 2));
      repeat (3) @(negedge mclk);
      chk(16'({cpin, wfo}), 16'({8'h4e >> i, 1'(i)} & 2'h3));
    end
    wr_reg(4'h1, 8'h02);
    repeat (2) @(negedge mclk);
    chk(16'(bout), 16'h0);
    wr_reg(4'h0, 8'h04);
    wr_reg(4'h1, 8'ha0);
    pin_a = 1'b1;
    wait_irq(1'b1, 20, k);
    chk(16'(k < 20), 16'h1);
    rd_reg(4'h1, 8'ha2);
    pin_a = 1'b0;
    wait_irq(1'b1, 20, k);
    chk(16'(k < 20), 16'h1);
    rd_reg(4'h1, 8'ha3);
    wr_reg(4'h1, 8'ha3);
    rd_reg(4'h1, 8'ha0);
    wr_reg(4'h1, 8'hd4);
    pin_a = 1'b1;
    wait_irq(1'b1, 20, k);
    chk(16'(k), 16'd20);
    pin_b = 1'b1;
    repeat (2) @(negedge mclk);
    pin_b = 1'b0;
    wait_irq(1'b1, 20, k);
    chk(16'(k), 16'd20);
    pin_b = 1'b1;
    wait_irq(1'b1, 30, k);
    chk(16'(k < 30), 16'h1);
    // falling edge only, eight cycle filter, flags cleared by the same write
    wr_reg(4'h1, 8'hcb);
    pin_b = 1'b0;
    wait_irq(1'b1, 30, k);
    chk(16'(k >= 8 && k < 30), 16'h1);
    rd_reg(4'h1, 8'hc9);
    pin_b = 1'b1;
    wait_irq(1'b1, 20, k);
    chk(16'(k), 16'd20);
    report_and_stop();
  end
endmodule
bind dct_top dct_top_sva dct_top_sva_i (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .word_capture(word_capture), .port_out_byte(port_out_byte),
  .word_timer_output(word_timer_output),
  .port_out_combined(port_out_combined), .byte_timer_out_pin(byte_timer_out_pin),
  .combined_out_pin(combined_out_pin), .word_timer_forced_output(word_timer_forced_output),
  .word_timer_reload(word_timer_reload), .shared_ctrl(shared_ctrl),
  .edge_detect(edge_detect), .timeout_irq(timeout_irq), .capture_irq(capture_irq));

//--- bench/dct_word_model.sv
// word timer datapath stand-in feeding capture and output level
`timescale 1ns/1ns
module dct_word_model (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic cap_go,
  input wire logic [15:0] cap_val,
  output dct_pkg::dct_capture_t word_capture,
  output logic word_timer_output
);
  logic [2:0] div_q;
  // value is garbage outside the strobe cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) word_capture <= '0;
    else word_capture <= {cap_go, cap_go ? cap_val : ~cap_val};
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 3'h0;
      word_timer_output <= 1'b0;
    end else begin
      div_q <= div_q + 3'h1;
      word_timer_output <= word_timer_output ^ (div_q == 3'h7);
    end
  end
endmodule

//--- hw/dct_pkg.sv
// types shared by the dual timer control block
package dct_pkg;

  typedef struct packed {
    logic enable;
    logic single_pass;
    logic timeout;
    logic [1:0] clk_sel;
    logic capture_ie;
    logic timeout_ie;
    logic pin_route;
  } dct_ctrl0_t;

  typedef struct packed {
    logic demod;
    logic pin_sel;
    logic [1:0] logic_edge;
    logic [1:0] submode_filter;
    logic init_byte;
    logic init_word;
  } dct_ctrl1_t;

  typedef enum logic [1:0] {
    DCT_COMB_AND,
    DCT_COMB_OR,
    DCT_COMB_NOR,
    DCT_COMB_NAND
  } dct_comb_t;

  typedef struct packed {
    logic strobe;
    logic [15:0] value;
  } dct_capture_t;

  typedef struct packed {
    logic rise;
    logic fall;
  } dct_edge_t;

endpackage

//--- hw/dct_prescale.sv
// free running prescaler producing the byte timer count pulse
`timescale 1ns/1ns
`include "dct_regs.svh"
module dct_prescale (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [1:0] sel,
  output logic tick
);

  logic [2:0] div_q;

  // free running, so the first pulse after enable may come early
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 3'h0;
    end else begin
      div_q <= div_q + 3'h1;
    end
  end

  always_comb begin
    case (sel)
      `DCT_PRE_DIV1: tick = 1'b1;
      `DCT_PRE_DIV2: tick = div_q[0];
      `DCT_PRE_DIV4: tick = &div_q[1:0];
      default: tick = &div_q;
    endcase
  end

endmodule

//--- hw/dct_regs.svh
// register offsets, field positions, reset values and filter counts of the dual timer block
`ifndef DCT_REGS_SVH
`define DCT_REGS_SVH

// register offsets inside the expanded bank
`define DCT_OFF_BYTE_CTRL 4'h0
`define DCT_OFF_SHARED_CTRL 4'h1
`define DCT_OFF_BYTE_LOW_HOLD 4'h4
`define DCT_OFF_BYTE_HIGH_HOLD 4'h5
`define DCT_OFF_WORD_RELOAD_LOW 4'h6
`define DCT_OFF_WORD_RELOAD_HIGH 4'h7
`define DCT_OFF_WORD_CAPTURE_LOW 4'h8
`define DCT_OFF_WORD_CAPTURE_HIGH 4'h9

// byte timer control field positions
`define DCT_C0_ENABLE 7
`define DCT_C0_TIMEOUT 5

// shared control field positions
`define DCT_C1_RISE_FLAG 1
`define DCT_C1_FALL_FLAG 0

// reset values
`define DCT_C0_RESET 8'h00
`define DCT_C1_RESET 8'h00
`define DCT_HOLD_RESET 8'h00
`define DCT_CAPTURE_RESET 16'h0000

// prescale selections
`define DCT_PRE_DIV1 2'h0
`define DCT_PRE_DIV2 2'h1
`define DCT_PRE_DIV4 2'h2
`define DCT_PRE_DIV8 2'h3

// glitch filter widths in system clock cycles
`define DCT_FILT_NONE 4'h1
`define DCT_FILT_SHORT 4'h4
`define DCT_FILT_LONG 4'h8

`endif

//--- hw/dct_top.sv
// register bank, byte timer and edge detection of the dual counter timer block
`timescale 1ns/1ns
`include "dct_regs.svh"
module dct_top (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire dct_pkg::dct_capture_t word_capture,
  input wire logic word_timer_output,
  input wire logic port_out_byte,
  input wire logic port_out_combined,
  input wire logic demod_input_pin_a,
  input wire logic demod_input_pin_b,
  output logic byte_timer_out_pin,
  output logic combined_out_pin,
  output logic byte_timer_output,
  output logic word_timer_forced_output,
  output logic [15:0] word_timer_reload,
  output dct_pkg::dct_ctrl1_t shared_ctrl,
  output dct_pkg::dct_edge_t edge_detect,
  output logic timeout_irq,
  output logic capture_irq
);

  dct_pkg::dct_ctrl0_t ctrl0_q;
  dct_pkg::dct_ctrl1_t ctrl1_q;
  logic en_q;
  logic timeout_q;
  logic rise_flag_q;
  logic fall_flag_q;
  logic [7:0] low_hold_q;
  logic [7:0] high_hold_q;
  logic [7:0] reload_low_q;
  logic [7:0] reload_high_q;
  logic [15:0] capture_q;
  logic [7:0] cnt_q;
  logic out_q;
  logic tick;
  logic start;
  logic terminal;
  logic wr_c0;
  logic wr_c1;
  logic [1:0] pin_a_sync_q;
  logic [1:0] pin_b_sync_q;
  logic sel_in;
  logic filt_q;
  logic filt_prev_q;
  logic [3:0] filt_cnt_q;
  logic [3:0] filt_width;
  logic rise_raw;
  logic fall_raw;
  logic rise_det;
  logic fall_det;
  logic word_eff;
  logic comb_out;
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;
  logic byte_pin_q;
  logic comb_pin_q;
  logic word_eff_q;
  logic to_irq_q;
  logic cap_irq_q;
  dct_pkg::dct_edge_t edge_q;

  assign wr_c0 = reg_wr_en && (reg_addr == `DCT_OFF_BYTE_CTRL);
  assign wr_c1 = reg_wr_en && (reg_addr == `DCT_OFF_SHARED_CTRL);

  // configuration fields of the byte timer control
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl0_q <= dct_pkg::dct_ctrl0_t'(`DCT_C0_RESET);
    end else if (wr_c0) begin
      ctrl0_q.single_pass <= reg_wdata[6];
      ctrl0_q.clk_sel <= reg_wdata[4:3];
      ctrl0_q.capture_ie <= reg_wdata[2];
      ctrl0_q.timeout_ie <= reg_wdata[1];
      ctrl0_q.pin_route <= reg_wdata[0];
    end
  end

  // shared control; low two bits only store levels in transmit mode
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl1_q <= dct_pkg::dct_ctrl1_t'(`DCT_C1_RESET);
    end else if (wr_c1) begin
      ctrl1_q.demod <= reg_wdata[7];
      ctrl1_q.pin_sel <= reg_wdata[6];
      ctrl1_q.logic_edge <= reg_wdata[5:4];
      ctrl1_q.submode_filter <= reg_wdata[3:2];
      if (!ctrl1_q.demod) begin
        ctrl1_q.init_byte <= reg_wdata[1];
        ctrl1_q.init_word <= reg_wdata[0];
      end
    end
  end

  // hold and reload bytes
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      low_hold_q <= `DCT_HOLD_RESET;
      high_hold_q <= `DCT_HOLD_RESET;
      reload_low_q <= `DCT_HOLD_RESET;
      reload_high_q <= `DCT_HOLD_RESET;
    end else if (reg_wr_en) begin
      case (reg_addr)
        `DCT_OFF_BYTE_LOW_HOLD: low_hold_q <= reg_wdata;
        `DCT_OFF_BYTE_HIGH_HOLD: high_hold_q <= reg_wdata;
        `DCT_OFF_WORD_RELOAD_LOW: reload_low_q <= reg_wdata;
        `DCT_OFF_WORD_RELOAD_HIGH: reload_high_q <= reg_wdata;
        default: begin
        end
      endcase
    end
  end

  // capture bytes follow the word timer only; bus writes never reach them
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      capture_q <= `DCT_CAPTURE_RESET;
    end else if (word_capture.strobe) begin
      capture_q <= word_capture.value;
    end
  end

  dct_prescale u_prescale (
    .mclk(mclk),
    .rst_n(rst_n),
    .sel(ctrl0_q.clk_sel),
    .tick(tick)
  );

  assign start = wr_c0 && reg_wdata[`DCT_C0_ENABLE] && !en_q;
  assign terminal = en_q && tick && (cnt_q == 8'h01);

  // running bit: write sets or stops, single pass stops at terminal count
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      en_q <= 1'b0;
    end else if (wr_c0) begin
      en_q <= reg_wdata[`DCT_C0_ENABLE];
    end else if (terminal && ctrl0_q.single_pass) begin
      en_q <= 1'b0;
    end
  end

  // down counter and byte timer output level
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 8'h00;
      out_q <= 1'b1;
    end else if (start) begin
      out_q <= ctrl1_q.init_byte;
      cnt_q <= ctrl1_q.init_byte ? high_hold_q : low_hold_q;
    end else if (!en_q) begin
      out_q <= ~ctrl1_q.init_byte;
    end else if (terminal) begin
      out_q <= ~out_q;
      if (ctrl0_q.single_pass) begin
        cnt_q <= 8'h00;
      end else begin
        cnt_q <= out_q ? low_hold_q : high_hold_q;
      end
    end else if (tick) begin
      cnt_q <= cnt_q - 8'h01;
    end
  end

  // time-out flag: a terminal count in the clearing cycle still sets it
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      timeout_q <= 1'b0;
    end else begin
      timeout_q <= terminal || (timeout_q && !(wr_c0 && reg_wdata[`DCT_C0_TIMEOUT]));
    end
  end

  // input pins pass two flops before use
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_a_sync_q <= 2'h0;
      pin_b_sync_q <= 2'h0;
    end else begin
      pin_a_sync_q <= {pin_a_sync_q[0], demod_input_pin_a};
      pin_b_sync_q <= {pin_b_sync_q[0], demod_input_pin_b};
    end
  end

  assign sel_in = ctrl1_q.pin_sel ? pin_b_sync_q[1] : pin_a_sync_q[1];

  always_comb begin
    case (ctrl1_q.submode_filter)
      2'h1: filt_width = `DCT_FILT_SHORT;
      2'h2: filt_width = `DCT_FILT_LONG;
      default: filt_width = `DCT_FILT_NONE;
    endcase
  end

  // glitch filter: level accepted once it differs for the full width
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      filt_q <= 1'b0;
      filt_prev_q <= 1'b0;
      filt_cnt_q <= 4'h0;
    end else begin
      filt_prev_q <= filt_q;
      if (sel_in == filt_q) begin
        filt_cnt_q <= 4'h0;
      end else if (filt_cnt_q + 4'h1 >= filt_width) begin
        filt_q <= sel_in;
        filt_cnt_q <= 4'h0;
      end else begin
        filt_cnt_q <= filt_cnt_q + 4'h1;
      end
    end
  end

  assign rise_raw = filt_q && !filt_prev_q;
  assign fall_raw = !filt_q && filt_prev_q;
  assign rise_det = ctrl1_q.demod && rise_raw &&
                    ((ctrl1_q.logic_edge == 2'h1) || (ctrl1_q.logic_edge == 2'h2));
  assign fall_det = ctrl1_q.demod && fall_raw &&
                    ((ctrl1_q.logic_edge == 2'h0) || (ctrl1_q.logic_edge == 2'h2));

  // edge flags; a new edge wins over a clearing write
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rise_flag_q <= 1'b0;
      fall_flag_q <= 1'b0;
    end else begin
      rise_flag_q <= rise_det ||
                     (rise_flag_q && !(wr_c1 && reg_wdata[`DCT_C1_RISE_FLAG]));
      fall_flag_q <= fall_det ||
                     (fall_flag_q && !(wr_c1 && reg_wdata[`DCT_C1_FALL_FLAG]));
    end
  end

  // word timer level forced by submode in transmit mode
  always_comb begin
    if (!ctrl1_q.demod && ctrl1_q.submode_filter == 2'h2) begin
      word_eff = 1'b0;
    end else if (!ctrl1_q.demod && ctrl1_q.submode_filter == 2'h3) begin
      word_eff = 1'b1;
    end else begin
      word_eff = word_timer_output;
    end
  end

  always_comb begin
    case (dct_pkg::dct_comb_t'(ctrl1_q.logic_edge))
      dct_pkg::DCT_COMB_AND: comb_out = out_q & word_eff;
      dct_pkg::DCT_COMB_OR: comb_out = out_q | word_eff;
      dct_pkg::DCT_COMB_NOR: comb_out = ~(out_q | word_eff);
      dct_pkg::DCT_COMB_NAND: comb_out = ~(out_q & word_eff);
      default: comb_out = 1'b0;
    endcase
  end

  // pins, interrupt requests and edge pulses
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      byte_pin_q <= 1'b0;
      comb_pin_q <= 1'b0;
      word_eff_q <= 1'b0;
      to_irq_q <= 1'b0;
      cap_irq_q <= 1'b0;
      edge_q <= '0;
    end else begin
      byte_pin_q <= ctrl0_q.pin_route ? out_q : port_out_byte;
      comb_pin_q <= (!ctrl1_q.demod && ctrl1_q.pin_sel) ? comb_out : port_out_combined;
      word_eff_q <= word_eff;
      to_irq_q <= terminal && ctrl0_q.timeout_ie;
      cap_irq_q <= (rise_det || fall_det) && ctrl0_q.capture_ie;
      edge_q.rise <= rise_det;
      edge_q.fall <= fall_det;
    end
  end

  // read mux; shared low bits show flags in demodulation mode
  always_comb begin
    case (reg_addr)
      `DCT_OFF_BYTE_CTRL: rdata_d = {en_q, ctrl0_q.single_pass, timeout_q, ctrl0_q.clk_sel,
                                     ctrl0_q.capture_ie, ctrl0_q.timeout_ie,
                                     ctrl0_q.pin_route};
      `DCT_OFF_SHARED_CTRL: rdata_d = ctrl1_q.demod ?
                                      {ctrl1_q[7:2], rise_flag_q, fall_flag_q} :
                                      ctrl1_q;
      `DCT_OFF_BYTE_LOW_HOLD: rdata_d = low_hold_q;
      `DCT_OFF_BYTE_HIGH_HOLD: rdata_d = high_hold_q;
      `DCT_OFF_WORD_RELOAD_LOW: rdata_d = reload_low_q;
      `DCT_OFF_WORD_RELOAD_HIGH: rdata_d = reload_high_q;
      `DCT_OFF_WORD_CAPTURE_LOW: rdata_d = capture_q[7:0];
      `DCT_OFF_WORD_CAPTURE_HIGH: rdata_d = capture_q[15:8];
      default: rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else if (reg_rd_en) begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign byte_timer_out_pin = byte_pin_q;
  assign combined_out_pin = comb_pin_q;
  assign byte_timer_output = out_q;
  assign word_timer_forced_output = word_eff_q;
  assign word_timer_reload = {reload_high_q, reload_low_q};
  assign shared_ctrl = ctrl1_q;
  assign edge_detect = edge_q;
  assign timeout_irq = to_irq_q;
  assign capture_irq = cap_irq_q;

endmodule
